// File: dv/i2c_bus_peer.sv
// Another party on the two-wire bus: makes start and stop on the pins.
// Assumes pull-ups, so both lines rest high between frames.
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_peer (
    input wire logic clk,
    output logic scl,
    output logic sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic w();
        repeat (4) @(posedge clk);
    endtask
    // Works from idle and as a repeated start
    task automatic start_c();
        @(posedge clk);
        sda <= 1'b1;
        w();
        scl <= 1'b1;
        w();
        sda <= 1'b0;
        w();
        scl <= 1'b0;
        w();
    endtask
    task automatic stop_c();
        @(posedge clk);
        sda <= 1'b0;
        w();
        scl <= 1'b1;
        w();
        sda <= 1'b1;
        w();
    endtask
endmodule // i2c_bus_peer

`default_nettype wire

// File: dv/i2c_status_mask_bench.sv
// Self-checking bench: APB register tasks, engine pulses, bus peer.
// Assumes the package offsets and the engine struct bit order.
`timescale 1ns/10ps
`default_nettype none

module i2c_status_mask_bench;
    localparam logic [7:0] E_BEG = 8'h80;
    localparam logic [7:0] E_ACK = 8'h40;
    localparam logic [7:0] E_NACK = 8'h20;
    localparam logic [7:0] E_COL = 8'h10;
    localparam logic [7:0] E_RX = 8'h08;
    localparam logic [7:0] E_TXD = 8'h04;
    logic clk;
    logic rst_n;
    i2c_stat_pkg::apb_req_t req;
    i2c_stat_pkg::apb_rsp_t rsp;
    i2c_stat_pkg::engine_evt_t eng;
    logic [7:0] rxb, txd, lv;
    logic txp, rxp, am, irq, scl, sda, hit_am, hit_rx, ce_in, err;
    logic [31:0] rd;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] byt [3] = '{8'hab, 8'ha8, 8'ha8};
    logic [31:0] msk [3] = '{32'h0, 32'h0, 32'h1};
    logic [31:0] hit [3] = '{32'h1, 32'h0, 32'h1};

    i2c_status_mask dut (.clk(clk), .rst_n(rst_n), .ce(ce_in),
        .apb_req(req), .apb_rsp(rsp), .scl_in(scl), .sda_in(sda),
        .eng(eng), .rx_shift_reg(rxb), .tx_data(txd), .tx_pending(txp),
        .rx_pulse(rxp), .addr_match(am), .irq(irq));
    i2c_bus_peer peer (.clk(clk), .scl(scl), .sda(sda));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task close_out();
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            close_out();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Answer is taken before the completing edge; ends at a falling edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(negedge clk);
            rdy = rsp.pready;
            rd = rsp.prdata;
            err = rsp.pslverr;
            @(posedge clk);
        end
        while (rdy !== 1'b1);
        req <= '0;
        @(negedge clk);
    endtask
    task st(input logic [15:0] m, input logic [15:0] e);
        xfer(1'b0, i2c_stat_pkg::OFF_STATUS, 32'h0);
        chk({16'h0, rd[15:0] & m}, {16'h0, e});
    endtask
    task ev(input logic [7:0] b, input logic [7:0] e);
        @(posedge clk);
        eng <= i2c_stat_pkg::engine_evt_t'(e | lv);
        rxb <= b;
        @(posedge clk);
        eng <= i2c_stat_pkg::engine_evt_t'(lv);
        // Pulses stand for one cycle only
        @(negedge clk);
        hit_am = am;
        hit_rx = rxp;
    endtask

    initial
    begin
        req = '0;
        eng = '0;
        rxb = 8'h00;
        lv = 8'h00;
        ce_in = 1'b1;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        st(16'hffff, 16'h0000);
        xfer(1'b0, i2c_stat_pkg::OFF_MASK, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, i2c_stat_pkg::OFF_MASK, 32'hffffffff);
        xfer(1'b0, i2c_stat_pkg::OFF_MASK, 32'h0);
        chk(rd, 32'h3ff);
        xfer(1'b0, 8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        peer.start_c();
        st(16'h0018, 16'h0008);
        peer.stop_c();
        st(16'h0018, 16'h0010);
        ev(8'h00, E_BEG);
        st(16'hc000, 16'h4000);
        ev(8'h00, E_ACK | E_NACK);
        st(16'hc000, 16'h8000);
        ev(8'h00, E_BEG);
        ev(8'h00, E_ACK);
        st(16'hc000, 16'h0000);
        ev(8'h00, E_COL);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, i2c_stat_pkg::OFF_EVT_EN, 32'h2);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, i2c_stat_pkg::OFF_EVT_CLR, 32'h2);
        chk({31'h0, irq}, 32'h0);
        st(16'h0400, 16'h0400);
        xfer(1'b1, i2c_stat_pkg::OFF_STATUS, 32'h0);
        st(16'h0400, 16'h0000);
        // Frozen block ignores the pulse and answers no transfer
        @(posedge clk);
        ce_in <= 1'b0;
        ev(8'h00, E_COL);
        chk({31'h0, rsp.pready}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        ce_in <= 1'b1;
        st(16'h0400, 16'h0000);
        xfer(1'b1, i2c_stat_pkg::OFF_TX, 32'h5a);
        st(16'h0081, 16'h0001);
        xfer(1'b1, i2c_stat_pkg::OFF_TX, 32'ha5);
        chk({24'h0, txd}, 32'h5a);
        st(16'h0081, 16'h0081);
        ev(8'h00, E_TXD);
        st(16'h0001, 16'h0000);
        xfer(1'b1, i2c_stat_pkg::OFF_STATUS, 32'h0);
        lv = 8'h02;
        ev(8'h00, 8'h00);
        xfer(1'b1, i2c_stat_pkg::OFF_TX, 32'h33);
        st(16'h0081, 16'h0080);
        lv = 8'h00;
        ev(8'h3c, E_RX);
        chk({31'h0, hit_rx}, 32'h1);
        st(16'h0002, 16'h0002);
        ev(8'hc3, E_RX);
        st(16'h0042, 16'h0042);
        xfer(1'b0, i2c_stat_pkg::OFF_RX, 32'h0);
        chk(rd, 32'h3c);
        st(16'h0002, 16'h0000);
        xfer(1'b1, i2c_stat_pkg::OFF_OWN, 32'h055);
        xfer(1'b1, i2c_stat_pkg::OFF_CTRL, 32'h2);
        lv = 8'h01;
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, i2c_stat_pkg::OFF_MASK, msk[i]);
            peer.start_c();
            ev(byt[i], E_RX);
            chk({31'h0, hit_am}, hit[i]);
            xfer(1'b0, i2c_stat_pkg::OFF_RX, 32'h0);
        end
        xfer(1'b1, i2c_stat_pkg::OFF_MASK, 32'h0);
        peer.start_c();
        ev(8'hab, E_RX);
        st(16'h0024, 16'h0004);
        xfer(1'b0, i2c_stat_pkg::OFF_RX, 32'h0);
        ev(8'h11, E_RX);
        st(16'h0020, 16'h0020);
        xfer(1'b0, i2c_stat_pkg::OFF_RX, 32'h0);
        peer.start_c();
        ev(8'h00, E_RX);
        st(16'h0204, 16'h0200);
        xfer(1'b0, i2c_stat_pkg::OFF_RX, 32'h0);
        peer.stop_c();
        st(16'h0200, 16'h0000);
        xfer(1'b1, i2c_stat_pkg::OFF_OWN, 32'h2a5);
        xfer(1'b1, i2c_stat_pkg::OFF_CTRL, 32'h3);
        peer.start_c();
        ev(8'hf4, E_RX);
        xfer(1'b0, i2c_stat_pkg::OFF_RX, 32'h0);
        ev(8'ha5, E_RX);
        chk({31'h0, hit_am}, 32'h1);
        st(16'h0100, 16'h0100);
        peer.stop_c();
        st(16'h0100, 16'h0000);
        close_out();
    end
endmodule // i2c_status_mask_bench

bind i2c_status_mask i2c_status_mask_sva sva (.clk(clk), .rst_n(rst_n),
    .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .scl_in(scl_in),
    .sda_in(sda_in), .eng(eng), .rx_shift_reg(rx_shift_reg),
    .tx_data(tx_data), .tx_pending(tx_pending), .rx_pulse(rx_pulse),
    .addr_match(addr_match), .irq(irq));

`default_nettype wire

// File: dv/i2c_status_mask_sva.sv
// Port-level checker for the two-wire status and mask block.
// Assumes a single clock domain and the package map of offsets.
`timescale 1ns/10ps
`default_nettype none

module i2c_status_mask_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire i2c_stat_pkg::apb_req_t apb_req,
    input wire i2c_stat_pkg::apb_rsp_t apb_rsp,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire i2c_stat_pkg::engine_evt_t eng,
    input wire logic [7:0] rx_shift_reg,
    input wire logic [7:0] tx_data,
    input wire logic tx_pending,
    input wire logic rx_pulse,
    input wire logic addr_match,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic acc;
    logic tx_wr;
    assign acc = apb_req.psel && apb_req.penable && ce;
    assign tx_wr = acc && apb_req.pwrite
        && apb_req.paddr == i2c_stat_pkg::OFF_TX;

    property p_ready;
        apb_req.psel |-> apb_rsp.pready == ce;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not ce");
    property p_tx_load;
        tx_wr && !eng.busy && !tx_pending |=>
            tx_pending && tx_data == $past(apb_req.pwdata[7:0]);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("tx load");
    property p_tx_refuse;
        tx_wr && tx_pending && !eng.tx_done |=> $stable(tx_data);
    endproperty
    a_tx_refuse: assert property (p_tx_refuse) else $error("tx kept");
    property p_tx_rise;
        $rose(tx_pending) |-> $past(tx_wr);
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx rise");
    property p_tx_fall;
        $fell(tx_pending) |-> $past(eng.tx_done);
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx fall");
    property p_stat_zero;
        acc && !apb_req.pwrite && apb_req.paddr == i2c_stat_pkg::OFF_STATUS
        |-> apb_rsp.prdata[31:16] == 16'h0000
            && apb_rsp.prdata[13:11] == 3'h0
            && apb_rsp.prdata[0] == tx_pending;
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("status");
    property p_mask_zero;
        acc && !apb_req.pwrite && apb_req.paddr == i2c_stat_pkg::OFF_MASK
        |-> apb_rsp.prdata[31:10] == 22'h000000;
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("mask");
    property p_rx_cause;
        rx_pulse |-> $past(eng.rx_byte_done && ce);
    endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("rx pulse");
    property p_match_cause;
        addr_match |-> $past(eng.rx_byte_done && eng.slave_mode);
    endproperty
    a_match_cause: assert property (p_match_cause) else $error("match");
    c_rx: cover property (rx_pulse);
    c_match: cover property (addr_match);
    c_txdone: cover property ($fell(tx_pending));
    c_irq: cover property ($rose(irq));
endmodule // i2c_status_mask_sva

`default_nettype wire

// File: verilog/i2c_stat_pkg.sv
// Constants and carrier types for the two-wire status and mask block.
// Assumes one 250 MHz clock shared by the APB side and the protocol engine.
package i2c_stat_pkg;

    // APB byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_OWN = 8'h0c;
    localparam logic [7:0] OFF_TX = 8'h10;
    localparam logic [7:0] OFF_RX = 8'h14;
    localparam logic [7:0] OFF_EVT_STAT = 8'h18;
    localparam logic [7:0] OFF_EVT_CLR = 8'h1c;
    localparam logic [7:0] OFF_EVT_EN = 8'h20;

    // Status bit positions
    localparam int ACK_B = 15;
    localparam int PROG_B = 14;
    localparam int COLL_B = 10;
    localparam int GC_B = 9;
    localparam int TEN_B = 8;
    localparam int WCOL_B = 7;
    localparam int OVF_B = 6;
    localparam int DA_B = 5;
    localparam int STOP_B = 4;
    localparam int START_B = 3;
    localparam int DIR_B = 2;
    localparam int RXF_B = 1;
    localparam int TXF_B = 0;

    // Bits software may clear by writing zero
    localparam logic [15:0] SW_CLR_MASK = 16'h04d8;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [9:0] MASK_RST = 10'h000;
    localparam logic [9:0] OWN_RST = 10'h000;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Control bit positions
    localparam int CTRL_TEN_B = 0;
    localparam int CTRL_SLV_B = 1;

    // Address constants
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [4:0] TEN_HDR = 5'h1e;

    // Event bit positions
    localparam int EV_RX = 0;
    localparam int EV_COLL = 1;
    localparam int EV_WCOL = 2;
    localparam int EV_OVF = 3;
    localparam int EV_STOP = 4;
    localparam int EV_GC = 5;
    localparam int EV_N = 6;
    localparam logic [EV_N-1:0] EVT_RST = 6'h00;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // One-cycle pulses and levels from the protocol engine
    typedef struct packed {
        logic mst_tx_begin;
        logic ack_end;
        logic ack_nack;
        logic collision;
        logic rx_byte_done;
        logic tx_done;
        logic busy;
        logic slave_mode;
    } engine_evt_t;

    typedef enum logic [2:0] {
        ADR_IDLE,
        ADR_FIRST,
        ADR_SECOND,
        ADR_DATA,
        ADR_IGNORE
    } adr_phase_t;

endpackage

// File: verilog/i2c_status_mask.sv
// Status flags, slave address mask and compare for a two-wire bus port.
// Assumes a protocol engine on the same clock gives one-cycle event pulses;
// scl_in and sda_in come straight from the pins.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module i2c_status_mask (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire i2c_stat_pkg::apb_req_t apb_req,
    output var i2c_stat_pkg::apb_rsp_t apb_rsp,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire i2c_stat_pkg::engine_evt_t eng,
    input wire logic [7:0] rx_shift_reg,
    output logic [7:0] tx_data,
    output logic tx_pending,
    output logic rx_pulse,
    output logic addr_match,
    output logic irq
);

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_lvl;
        logic sda_lvl;
        logic [15:0] stat;
        logic [9:0] mask;
        logic [1:0] ctrl;
        logic [9:0] own;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [i2c_stat_pkg::EV_N-1:0] evt;
        logic [i2c_stat_pkg::EV_N-1:0] evt_en;
        i2c_stat_pkg::adr_phase_t phase;
        logic rx_pulse;
        logic addr_match;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [31:0] rdata;
    logic unmapped;

    always_comb
    begin
        logic acc;
        logic wr;
        logic rd;
        logic rx_read;
        logic scl_new;
        logic sda_new;
        logic start_det;
        logic stop_det;
        logic slave;
        logic take;
        logic match;
        logic busy;
        logic [7:0] b;
        logic [7:0] a;
        acc = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        rx_read = 1'b0;
        scl_new = 1'b0;
        sda_new = 1'b0;
        start_det = 1'b0;
        stop_det = 1'b0;
        slave = 1'b0;
        take = 1'b0;
        match = 1'b0;
        busy = 1'b0;
        b = rx_shift_reg;
        a = apb_req.paddr;

        state_next = state_reg;
        state_next.rx_pulse = 1'b0;
        state_next.addr_match = 1'b0;

        acc = apb_req.psel && apb_req.penable && ce;
        wr = acc && apb_req.pwrite;
        rd = acc && !apb_req.pwrite;
        rx_read = rd && (a == i2c_stat_pkg::OFF_RX);

        // Read mux; unused bits stay zero
        unmapped = 1'b0;
        rdata = 32'h0000_0000;
        case (a)
            i2c_stat_pkg::OFF_STATUS:
                rdata = {16'h0000, state_reg.stat & 16'hc7ff};
            i2c_stat_pkg::OFF_MASK:
                rdata = {22'h000000, state_reg.mask};
            i2c_stat_pkg::OFF_CTRL:
                rdata = {30'h00000000, state_reg.ctrl};
            i2c_stat_pkg::OFF_OWN:
                rdata = {22'h000000, state_reg.own};
            i2c_stat_pkg::OFF_TX:
                rdata = {24'h000000, state_reg.tx};
            i2c_stat_pkg::OFF_RX:
                rdata = {24'h000000, state_reg.rx};
            i2c_stat_pkg::OFF_EVT_STAT:
                rdata = {26'h0000000, state_reg.evt};
            i2c_stat_pkg::OFF_EVT_CLR:
                rdata = 32'h0000_0000;
            i2c_stat_pkg::OFF_EVT_EN:
                rdata = {26'h0000000, state_reg.evt_en};
            default:
                unmapped = 1'b1;
        endcase

        // Pin filter: level moves only when second and third stage agree
        state_next.scl_sync = {state_reg.scl_sync[1:0], scl_in};
        state_next.sda_sync = {state_reg.sda_sync[1:0], sda_in};
        scl_new = state_reg.scl_lvl;
        sda_new = state_reg.sda_lvl;
        if (state_reg.scl_sync[1] == state_reg.scl_sync[2])
        begin
            scl_new = state_reg.scl_sync[2];
        end
        if (state_reg.sda_sync[1] == state_reg.sda_sync[2])
        begin
            sda_new = state_reg.sda_sync[2];
        end
        state_next.scl_lvl = scl_new;
        state_next.sda_lvl = sda_new;
        start_det = state_reg.scl_lvl && scl_new
            && state_reg.sda_lvl && !sda_new;
        stop_det = state_reg.scl_lvl && scl_new
            && !state_reg.sda_lvl && sda_new;

        // Software writes; zero clears the clearable status bits
        if (wr)
        begin
            case (a)
                i2c_stat_pkg::OFF_STATUS:
                    state_next.stat = state_reg.stat
                        & ~(i2c_stat_pkg::SW_CLR_MASK
                        & ~apb_req.pwdata[15:0]);
                i2c_stat_pkg::OFF_MASK:
                    state_next.mask = apb_req.pwdata[9:0];
                i2c_stat_pkg::OFF_CTRL:
                    state_next.ctrl = apb_req.pwdata[1:0];
                i2c_stat_pkg::OFF_OWN:
                    state_next.own = apb_req.pwdata[9:0];
                i2c_stat_pkg::OFF_EVT_CLR:
                    state_next.evt = state_reg.evt
                        & ~apb_req.pwdata[i2c_stat_pkg::EV_N-1:0];
                i2c_stat_pkg::OFF_EVT_EN:
                    state_next.evt_en =
                        apb_req.pwdata[i2c_stat_pkg::EV_N-1:0];
                default:
                    ;
            endcase
        end

        // Transmit holding register; busy covers an unsent byte too
        if (eng.tx_done)
        begin
            state_next.stat[i2c_stat_pkg::TXF_B] = 1'b0;
        end
        busy = eng.busy || state_reg.stat[i2c_stat_pkg::TXF_B];
        if (wr && (a == i2c_stat_pkg::OFF_TX))
        begin
            if (busy)
            begin
                state_next.stat[i2c_stat_pkg::WCOL_B] = 1'b1;
                state_next.evt[i2c_stat_pkg::EV_WCOL] = 1'b1;
            end
            else
            begin
                state_next.tx = apb_req.pwdata[7:0];
                state_next.stat[i2c_stat_pkg::TXF_B] = 1'b1;
            end
        end

        // Master transmit progress and acknowledge result
        if (eng.ack_end)
        begin
            state_next.stat[i2c_stat_pkg::ACK_B] = eng.ack_nack;
            state_next.stat[i2c_stat_pkg::PROG_B] = 1'b0;
        end
        if (eng.mst_tx_begin)
        begin
            state_next.stat[i2c_stat_pkg::PROG_B] = 1'b1;
        end
        if (eng.collision)
        begin
            state_next.stat[i2c_stat_pkg::COLL_B] = 1'b1;
            state_next.evt[i2c_stat_pkg::EV_COLL] = 1'b1;
        end

        // Bus conditions
        if (start_det)
        begin
            state_next.stat[i2c_stat_pkg::START_B] = 1'b1;
            state_next.stat[i2c_stat_pkg::STOP_B] = 1'b0;
            state_next.phase = i2c_stat_pkg::ADR_FIRST;
        end
        if (stop_det)
        begin
            state_next.stat[i2c_stat_pkg::STOP_B] = 1'b1;
            state_next.stat[i2c_stat_pkg::START_B] = 1'b0;
            state_next.stat[i2c_stat_pkg::GC_B] = 1'b0;
            state_next.stat[i2c_stat_pkg::TEN_B] = 1'b0;
            state_next.evt[i2c_stat_pkg::EV_STOP] = 1'b1;
            state_next.phase = i2c_stat_pkg::ADR_IDLE;
        end

        // Slave address compare on the address bytes after a start; data bytes are taken without compare
        slave = eng.slave_mode && state_reg.ctrl[i2c_stat_pkg::CTRL_SLV_B];
        take = eng.rx_byte_done && !slave;
        if (eng.rx_byte_done && slave)
        begin
            case (state_reg.phase)
                i2c_stat_pkg::ADR_FIRST:
                begin
                    if (state_reg.ctrl[i2c_stat_pkg::CTRL_TEN_B])
                    begin
                        if ((b[7:3] == i2c_stat_pkg::TEN_HDR)
                            && (((b[2:1] ^ state_reg.own[9:8])
                            & ~state_reg.mask[9:8]) == 2'h0))
                        begin
                            if (!b[0])
                            begin
                                take = 1'b1;
                                state_next.phase =
                                    i2c_stat_pkg::ADR_SECOND;
                            end
                            else if (state_reg.stat[i2c_stat_pkg::TEN_B])
                            begin
                                // Read header after a repeated start
                                match = 1'b1;
                            end
                            else
                            begin
                                state_next.phase =
                                    i2c_stat_pkg::ADR_IGNORE;
                            end
                        end
                        else
                        begin
                            state_next.phase = i2c_stat_pkg::ADR_IGNORE;
                        end
                    end
                    else if (b == i2c_stat_pkg::GC_ADDR)
                    begin
                        match = 1'b1;
                        state_next.stat[i2c_stat_pkg::GC_B] = 1'b1;
                        state_next.evt[i2c_stat_pkg::EV_GC] = 1'b1;
                    end
                    else if (((b[7:1] ^ state_reg.own[6:0])
                        & ~state_reg.mask[6:0]) == 7'h00)
                    begin
                        match = 1'b1;
                    end
                    else
                    begin
                        state_next.phase = i2c_stat_pkg::ADR_IGNORE;
                    end
                    if (match)
                    begin
                        state_next.stat[i2c_stat_pkg::DIR_B] = b[0];
                    end
                end
                i2c_stat_pkg::ADR_SECOND:
                begin
                    if (((b ^ state_reg.own[7:0])
                        & ~state_reg.mask[7:0]) == 8'h00)
                    begin
                        match = 1'b1;
                        state_next.stat[i2c_stat_pkg::TEN_B] = 1'b1;
                        state_next.stat[i2c_stat_pkg::DIR_B] = 1'b0;
                    end
                    else
                    begin
                        state_next.phase = i2c_stat_pkg::ADR_IGNORE;
                    end
                end
                i2c_stat_pkg::ADR_DATA:
                begin
                    take = 1'b1;
                    state_next.stat[i2c_stat_pkg::DA_B] = 1'b1;
                end
                default:
                    ;
            endcase
            if (match)
            begin
                take = 1'b1;
                state_next.addr_match = 1'b1;
                state_next.stat[i2c_stat_pkg::DA_B] = 1'b0;
                state_next.phase = i2c_stat_pkg::ADR_DATA;
            end
        end

        // Receive buffer; a read and a new byte in one cycle keep the flag
        if (rx_read)
        begin
            state_next.stat[i2c_stat_pkg::RXF_B] = 1'b0;
        end
        if (take)
        begin
            if (state_reg.stat[i2c_stat_pkg::RXF_B] && !rx_read)
            begin
                // Unread byte is kept; the new one is lost
                state_next.stat[i2c_stat_pkg::OVF_B] = 1'b1;
                state_next.evt[i2c_stat_pkg::EV_OVF] = 1'b1;
            end
            else
            begin
                state_next.rx = b;
                state_next.stat[i2c_stat_pkg::RXF_B] = 1'b1;
                state_next.rx_pulse = 1'b1;
                state_next.evt[i2c_stat_pkg::EV_RX] = 1'b1;
            end
        end

        // Bits 13..11 never store anything
        state_next.stat[13:11] = 3'h0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.scl_sync <= 3'h7;
            state_reg.sda_sync <= 3'h7;
            state_reg.scl_lvl <= 1'b1;
            state_reg.sda_lvl <= 1'b1;
            state_reg.stat <= i2c_stat_pkg::STATUS_RST;
            state_reg.mask <= i2c_stat_pkg::MASK_RST;
            state_reg.ctrl <= i2c_stat_pkg::CTRL_RST;
            state_reg.own <= i2c_stat_pkg::OWN_RST;
            state_reg.tx <= 8'h00;
            state_reg.rx <= 8'h00;
            state_reg.evt <= i2c_stat_pkg::EVT_RST;
            state_reg.evt_en <= i2c_stat_pkg::EVT_RST;
            state_reg.phase <= i2c_stat_pkg::ADR_IDLE;
            state_reg.rx_pulse <= 1'b0;
            state_reg.addr_match <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    // Ready follows ce so a frozen block completes no transfer
    assign apb_rsp.pready = ce;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && unmapped;
    assign apb_rsp.prdata = rdata;
    assign tx_data = state_reg.tx;
    assign tx_pending = state_reg.stat[i2c_stat_pkg::TXF_B];
    assign rx_pulse = state_reg.rx_pulse;
    assign addr_match = state_reg.addr_match;
    assign irq = |(state_reg.evt & state_reg.evt_en);

endmodule // i2c_status_mask

`default_nettype wire
